// file: rtl/ceu_defs.svh
/*
  Constants of the core exception unit: cause codes, register offsets,
  field positions and reset values.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef CEU_DEFS_SVH
`define CEU_DEFS_SVH

// ----------------------------------------------------------------------
// Exception cause codes
// ----------------------------------------------------------------------
`define CEU_EXC_SSTEP      6'h10
`define CEU_EXC_TRACE      6'h11
`define CEU_EXC_UNDEF      6'h21
`define CEU_EXC_ILLCOMB    6'h22
`define CEU_EXC_DPROT      6'h23
`define CEU_EXC_DMISAL     6'h24
`define CEU_EXC_UNRECOV    6'h25
`define CEU_EXC_DMISS      6'h26
`define CEU_EXC_DMULTI     6'h27
`define CEU_EXC_WATCH      6'h28
`define CEU_EXC_IACCESS    6'h29
`define CEU_EXC_IMISAL     6'h2a
`define CEU_EXC_IPROT      6'h2b
`define CEU_EXC_IMISS      6'h2c
`define CEU_EXC_IMULTI     6'h2d
`define CEU_EXC_SUPER      6'h2e

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CEU_OFF_STATUS     12'h000
`define CEU_OFF_ERA        12'h004
`define CEU_OFF_NRA        12'h008
`define CEU_OFF_CTRL       12'h00c

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CEU_CTL_SSTEP      0
`define CEU_CTL_TRACE      1
`define CEU_CTL_WATCH      2
`define CEU_STS_NESTED     6
`define CEU_CTL_RESET      3'h0
`define CEU_CAUSE_RESET    6'h00
`define CEU_ADDR_RESET     32'h0000_0000

`endif

// file: rtl/ceu_pkg.sv
/*
  Types of the core exception unit.
  Assumes ceu_defs.svh is on the include path.
*/
`include "ceu_defs.svh"

package ceu_pkg;

  // Conditions reported by the pipeline for the instruction one stage
  // before completion.
  typedef struct packed {
    logic        valid;        // Instruction enters completion next cycle.
    logic [31:0] pc;           // Address of the instruction.
    logic [31:0] next_pc;      // Address of the instruction that follows.
    logic [31:0] fetch_target; // Target of an indirect branch.
    logic        indirect;     // The fetch came from an indirect branch.
    logic        in_handler;   // Exception, NMI, reset or emulation code.
    logic        if_multi;
    logic        if_misal;
    logic        if_prot;
    logic        if_miss;
    logic        if_access;
    logic        watch_match;
    logic        undef;
    logic        illegal_comb;
    logic        sup_misuse;   // Supervisor register or instruction.
    logic        sup_data;     // User-mode data access to supervisor space.
    logic        dual_mmr;     // Both generators hit registers at once.
    logic        d0_multi;
    logic        d0_misal;
    logic        d0_prot;
    logic        d0_miss;
    logic        d1_multi;
    logic        d1_misal;
    logic        d1_prot;
    logic        d1_miss;
    logic        force_exc;
    logic [3:0]  force_code;
    logic        trace_ovf;
  } ceu_req_t;

  // Outcome of the priority selection.
  typedef struct packed {
    logic       hit;
    logic       error;
    logic       use_target;
    logic [5:0] cause;
  } ceu_sel_t;

  // Event presented to the sequencer.
  typedef struct packed {
    logic        taken;
    logic        unrecov;
    logic        commit;
    logic        abort_excepting;
    logic        abort_younger;
    logic [5:0]  cause;
    logic [31:0] ret_addr;
  } ceu_evt_t;

  // Whole state of the top module.
  typedef struct packed {
    logic [2:0]  ctl;
    logic [5:0]  cause;
    logic        nested;
    logic [31:0] era;
    logic [31:0] nra;
    ceu_evt_t    evt;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ceu_state_t;

endpackage

// file: rtl/ceu_prio.sv
/*
  Priority selector: picks the single highest ranked exception condition.
  Assumes all inputs are on the core clock and already qualified.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ceu_defs.svh"

module ceu_prio
  import ceu_pkg::*;
(
  input  wire ceu_req_t  req,
  input  wire logic      sstep_en,
  input  wire logic      trace_en,
  input  wire logic      watch_en,
  output var ceu_sel_t   sel
);

  // Builds an error-type selection.
  function automatic ceu_sel_t err(input logic [5:0] c);
    err = '{hit: 1'b1, error: 1'b1, use_target: 1'b0, cause: c};
  endfunction

  // Builds a service-type selection.
  function automatic ceu_sel_t svc(input logic [5:0] c);
    svc = '{hit: 1'b1, error: 1'b0, use_target: 1'b0, cause: c};
  endfunction

  // ----------------------------------------------------------------------
  // Ranked chain, highest first; only one cause survives.
  // ----------------------------------------------------------------------
  always_comb
  begin
    sel = '0;
    if (!req.valid)
      sel = '0;
    else if (req.if_multi)
      sel = err(`CEU_EXC_IMULTI);                       // [RL14] [RL17]
    else if (req.if_misal && req.indirect)
    begin
      // Relative branches are aligned by construction.
      sel = err(`CEU_EXC_IMISAL);                       // [RL13]
      sel.use_target = 1'b1;                            // [RL13]
    end
    else if (req.if_prot)
      sel = err(`CEU_EXC_IPROT);                        // [RL14]
    else if (req.if_miss)
      sel = err(`CEU_EXC_IMISS);                        // [RL14]
    else if (req.if_access)
      sel = err(`CEU_EXC_IACCESS);                      // [RL17]
    else if (req.watch_match && watch_en)
      sel = err(`CEU_EXC_WATCH);                        // [RL12]
    else if (req.undef)
      sel = err(`CEU_EXC_UNDEF);                        // [RL8]
    else if (req.illegal_comb)
      sel = err(`CEU_EXC_ILLCOMB);                      // [RL8]
    else if (req.sup_misuse)
      sel = err(`CEU_EXC_SUPER);                        // [RL15]
    else if (req.d0_multi)
      sel = err(`CEU_EXC_DMULTI);                       // [RL11]
    else if (req.d0_misal)
      sel = err(`CEU_EXC_DMISAL);                       // [RL10]
    else if (req.d0_prot || req.sup_data || req.dual_mmr)
      sel = err(`CEU_EXC_DPROT);                        // [RL9]
    else if (req.d0_miss)
      sel = err(`CEU_EXC_DMISS);                        // [RL11]
    else if (req.d1_multi)
      sel = err(`CEU_EXC_DMULTI);                       // [RL22]
    else if (req.d1_misal)
      sel = err(`CEU_EXC_DMISAL);                       // [RL22]
    else if (req.d1_prot)
      sel = err(`CEU_EXC_DPROT);                        // [RL22]
    else if (req.d1_miss)
      sel = err(`CEU_EXC_DMISS);                        // [RL22]
    else if (req.force_exc)
      sel = svc({2'b00, req.force_code});               // [RL5]
    else if (sstep_en)
      sel = svc(`CEU_EXC_SSTEP);                        // [RL6]
    else if (req.trace_ovf && trace_en)
      sel = svc(`CEU_EXC_TRACE);                        // [RL7]
  end

endmodule // ceu_prio

`default_nettype wire

// file: rtl/ceu_nest.sv
/*
  Nested-exception filter: turns any exception raised inside handler,
  reset or emulation code into the unrecoverable event.
  Assumes in_handler is valid whenever the request is valid.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ceu_defs.svh"

module ceu_nest
  import ceu_pkg::*;
(
  input  wire ceu_sel_t  sel_in,
  input  wire logic      in_handler,
  output var ceu_sel_t   sel_out,
  output logic           nested
);

  // ----------------------------------------------------------------------
  // Replace the cause and force error handling on the offending address.
  // ----------------------------------------------------------------------
  always_comb
  begin
    sel_out = sel_in;
    nested  = sel_in.hit && in_handler;
    if (nested)
    begin
      // A misaligned-target address would hide the culprit, so the
      // instruction's own address is kept.
      sel_out.error      = 1'b1;                        // [RL18]
      sel_out.use_target = 1'b0;                        // [RL19]
      sel_out.cause      = `CEU_EXC_UNRECOV;            // [RL18]
    end
  end

endmodule // ceu_nest

`default_nettype wire

// file: rtl/ceu_top.sv
/*
  Core exception unit: selects the exception of the completing
  instruction, records cause and return address, and drives the
  commit and abort controls of the pipeline. Registers over APB.
  Assumes the pipeline presents each instruction's conditions one cycle
  before it reaches completion, on the same clock, and redirects fetch
  to the handler on the taken pulse.
*/
// Implementation choices: the register addresses and register access over APB.
// What this block does
// [RL1] Exceptions follow the instruction at completion.
// [RL2] Service type commits; return is next instruction.
// [RL3] Error type aborts; return is own address.
// [RL4] Every taken exception writes the cause field.
// [RL5] Force instruction is service; immediate gives cause.
// [RL6] Single step raises service cause 0x10.
// [RL7] Enabled trace overflow raises service 0x11.
// [RL8] Undefined 0x21, illegal combination 0x22, error.
// [RL9] Supervisor data, protection, dual register: 0x23.
// [RL10] Misaligned data access raises error 0x24.
// [RL11] Data lookup miss 0x26, multiple hits 0x27.
// [RL12] Watchpoint raises 0x28 only when enabled.
// [RL13] Indirect misaligned fetch 0x2A saves target address.
// [RL14] Fetch protection 0x2B, miss 0x2C, multiple 0x2D.
// [RL15] User use of supervisor resource: 0x2E.
// [RL16] Only the highest priority exception is taken.
// [RL17] Fixed ranking, unrecoverable first, fetch causes next.
// [RL18] Nested exception: no writeback, not taken, 0x25.
// [RL19] Nested case leaves NMI return address alone.
// [RL20] Younger instructions aborted; errors abort the culprit.
// [RL21] Status register read-only and supervisor-only.
// [RL22] Second generator, force, step, trace rank last.
// [RL23] Pulse, cause, address shown at completion.
`timescale 1ns/1ps
`default_nettype none
`include "ceu_defs.svh"

module ceu_top
  import ceu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [2:0]  pprot,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire ceu_req_t    req,
  input  wire logic        nmi_entry,
  output var ceu_evt_t     evt
);

  // ----------------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------------
  ceu_state_t state_reg;   // All flip-flops of the block.
  ceu_state_t state_next;  // Next value of the same.
  ceu_sel_t   sel_raw;     // Highest ranked raw condition.
  ceu_sel_t   sel;         // After nested-exception filtering.
  logic       nested;      // Exception raised inside handler code.
  logic       apb_done;    // Access phase completes at this edge.
  logic       priv;        // Access comes from supervisor mode.
  logic [31:0] rd_word;    // Word returned for a read.
  logic       bad_addr;    // Address maps to no register.

  // Ranks all conditions of the instruction.
  ceu_prio u_prio (
    .req      (req),
    .sstep_en (state_reg.ctl[`CEU_CTL_SSTEP]),
    .trace_en (state_reg.ctl[`CEU_CTL_TRACE]),
    .watch_en (state_reg.ctl[`CEU_CTL_WATCH]),
    .sel      (sel_raw)
  );

  // Catches exceptions taken while already in handler code.
  ceu_nest u_nest (
    .sel_in     (sel_raw),
    .in_handler (req.in_handler),
    .sel_out    (sel),
    .nested     (nested)
  );

  // ----------------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------------
  // Map, one aligned word each:
  //   0x000 status: cause [5:0], nested [6].
  //   0x004 exception return address.
  //   0x008 NMI return address.
  //   0x00c control: step, trace, watch.
  // Reserved bits of every register read as zero.
  always_comb
  begin
    rd_word  = '0;
    bad_addr = 1'b0;
    unique case (paddr)
      `CEU_OFF_STATUS:
      begin
        rd_word[5:0]           = state_reg.cause;
        rd_word[`CEU_STS_NESTED] = state_reg.nested;
      end
      `CEU_OFF_ERA:  rd_word = state_reg.era;
      `CEU_OFF_NRA:  rd_word = state_reg.nra;
      `CEU_OFF_CTRL: rd_word[2:0] = state_reg.ctl;
      default:       bad_addr = 1'b1;
    endcase
  end

  assign priv     = pprot[0];
  assign apb_done = psel && penable && state_reg.pready;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // One pass decides the event of the instruction now presented
  // and the APB answer. Both land in the same register, so the
  // sequencer and software see them one cycle later.
  always_comb
  begin
    state_next = state_reg;

    // Taken, unrecov and abort flags are single-cycle pulses by default; commit follows valid.
    state_next.evt.taken           = 1'b0;
    state_next.evt.unrecov         = 1'b0;
    state_next.evt.commit          = req.valid;
    state_next.evt.abort_excepting = 1'b0;
    state_next.evt.abort_younger   = 1'b0;

    // The NMI return address only moves on NMI entry, never on an
    // exception of any kind.
    if (nmi_entry)
      state_next.nra = req.pc;                          // [RL19]

    // Decision is registered so that it lines up with the completion
    // stage one cycle later.
    if (sel.hit)                                        // [RL23]
    begin
      // Everything behind the culprit is discarded so nothing younger
      // runs before the handler.
      state_next.evt.abort_younger = 1'b1;              // [RL1] [RL20]
      state_next.evt.cause         = sel.cause;         // [RL16]
      state_next.cause             = sel.cause;         // [RL4]
      state_next.nested            = nested;
      if (sel.error)
      begin
        state_next.evt.commit          = 1'b0;          // [RL3]
        state_next.evt.abort_excepting = 1'b1;          // [RL20]
        state_next.evt.ret_addr        = sel.use_target ?
                                         req.fetch_target : req.pc; // [RL3] [RL13]
      end
      else
      begin
        state_next.evt.commit   = 1'b1;                 // [RL2]
        state_next.evt.ret_addr = req.next_pc;          // [RL2]
      end
      state_next.era = state_next.evt.ret_addr;         // [RL19]
      if (nested)
      begin
        // Not taken: writebacks suppressed, only flagged.
        state_next.evt.unrecov = 1'b1;                  // [RL18]
      end
      else
        state_next.evt.taken = 1'b1;                    // [RL1]
    end

    // APB: one wait state, then ready with data and error together.
    // The fixed wait state keeps the read mux out of the path
    // from the address pins to prdata, at the cost of a cycle.
    state_next.pready  = psel && penable && !state_reg.pready;
    state_next.pslverr = 1'b0;
    state_next.prdata  = '0;
    if (psel && penable && !state_reg.pready)
    begin
      // Status is read-only and hidden from user mode.
      if (bad_addr || !priv)
        state_next.pslverr = 1'b1;                      // [RL21]
      else if (pwrite && paddr != `CEU_OFF_CTRL)
        state_next.pslverr = 1'b1;                      // [RL21]
      else if (!pwrite)
        state_next.prdata = rd_word;
    end

    // A write takes effect only at the edge that completes it.
    if (apb_done && pwrite && !state_reg.pslverr && paddr == `CEU_OFF_CTRL)
      state_next.ctl = pwdata[2:0];                     // [RL12]
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset needs no clock; its branch loads constants only.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg       <= '0;
      state_reg.ctl   <= `CEU_CTL_RESET;
      state_reg.cause <= `CEU_CAUSE_RESET;
      state_reg.era   <= `CEU_ADDR_RESET;
      state_reg.nra   <= `CEU_ADDR_RESET;
    end
    else
      state_reg <= state_next;
  end

  // Every output comes straight from the state register.
  assign evt     = state_reg.evt;
  assign prdata  = state_reg.prdata;
  assign pready  = state_reg.pready;
  assign pslverr = state_reg.pslverr;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // The checks watch the registered outputs one cycle after the
  // decision, the same view the sequencer has.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  taken_cause_rec_a: assert property (evt.taken |-> state_reg.cause == evt.cause) // [RL4]
    else $error("cause field not updated with taken exception");

  service_commit_a: assert property (                                  // [RL2]
    $past(sel.hit) && !$past(sel.error) |-> evt.commit && evt.ret_addr == $past(req.next_pc))
    else $error("service exception did not commit or wrong return");

  error_abort_a: assert property (                                     // [RL3]
    $past(sel.hit) && $past(sel.error) && !$past(sel.use_target) |->
      !evt.commit && evt.abort_excepting && evt.ret_addr == $past(req.pc))
    else $error("error exception committed or wrong return");

  fetch_target_a: assert property (                                    // [RL13]
    (req.valid && !req.in_handler && !req.if_multi && req.if_misal && req.indirect)
      |=> evt.taken && evt.cause == `CEU_EXC_IMISAL && evt.ret_addr == $past(req.fetch_target))
    else $error("misaligned fetch did not save target");

  fetch_multi_a: assert property (                                     // [RL17]
    (req.valid && !req.in_handler && req.if_multi) |=> evt.cause == `CEU_EXC_IMULTI)
    else $error("fetch multiple hit not ranked first");

  single_step_a: assert property (                                     // [RL6]
    (req.valid && state_reg.ctl[`CEU_CTL_SSTEP]) |=> (evt.taken || evt.unrecov))
    else $error("single step instruction raised nothing");

  nested_event_a: assert property (                                    // [RL18]
    (sel_raw.hit && req.in_handler) |=>
      evt.unrecov && !evt.taken && !evt.commit && evt.cause == `CEU_EXC_UNRECOV)
    else $error("nested exception handled wrongly");

  nmi_keep_a: assert property (                                        // [RL19]
    (evt.unrecov && !$past(nmi_entry)) |-> state_reg.nra == $past(state_reg.nra))
    else $error("nmi return changed on nested exception");

  younger_abort_a: assert property ((evt.taken || evt.unrecov) |-> evt.abort_younger) // [RL20]
    else $error("younger instructions not aborted");

  status_protect_a: assert property (                                  // [RL21]
    (psel && penable && pready && paddr == `CEU_OFF_STATUS && (pwrite || !pprot[0]))
      |-> pslverr)
    else $error("status register access not refused");

  // A nested event is never also a taken one.
  one_event_a: assert property (!(evt.taken && evt.unrecov)) // [RL18]
    else $error("taken and unrecoverable together");

  // Conditions without a valid instruction raise nothing.
  idle_quiet_a: assert property (!req.valid |=> !evt.taken && !evt.unrecov) // [RL1]
    else $error("event without a valid instruction");

  // Ready is a single-cycle pulse.
  ready_pulse_a: assert property (pready |=> !pready) // [RL21]
    else $error("ready held for more than one cycle");

  // An error is only shown together with ready.
  err_ready_a: assert property (pslverr |-> pready) // [RL21]
    else $error("error shown without ready");

  // A completed control write lands at its own edge.
  ctl_write_a: assert property ( // [RL12]
    (apb_done && pwrite && !pslverr && paddr == `CEU_OFF_CTRL)
      |=> state_reg.ctl == 3'($past(pwdata)))
    else $error("control write did not land");

  cover_service_c: cover property (evt.taken && evt.commit);
  cover_error_c:   cover property (evt.taken && evt.abort_excepting);
  cover_nested_c:  cover property (evt.unrecov);
  cover_read_c:    cover property (psel && penable && pready && !pwrite && !pslverr);
  cover_step_c:    cover property (evt.taken && evt.cause == `CEU_EXC_SSTEP);

endmodule // ceu_top

`default_nettype wire

// file: testbench/ceu_pipe_model.sv
/*
  Pipeline model: presents one instruction's conditions to the exception
  unit one cycle after the bench hands it a command.
  Assumes commands change by non-blocking assignment after a rising pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module ceu_pipe_model
  import ceu_pkg::*;
(
  input  wire logic     pclk,    // Core clock.
  input  wire logic     presetn, // Reset, active low.
  input  wire ceu_req_t cmd,     // Instruction to present next.
  input  wire logic     cmd_v,   // Command present this cycle.
  output var  ceu_req_t req      // Conditions seen by the unit.
);
  // ----------------------------------------------------------------------
  // Presentation register
  // ----------------------------------------------------------------------
  // Between commands every flag toggles with valid low, so a unit that
  // acted on a stale or unqualified request shows it at once.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req <= '0;
    else if (cmd_v)
      req <= cmd;
    else
      req <= {1'b0, ~req[$bits(ceu_req_t)-2:0]};
  end
endmodule // ceu_pipe_model
`default_nettype wire

// file: testbench/tb_ceu_top.sv
/*
  Bench of the core exception unit: random instructions through the
  pipeline model, a scoreboard of the expected event, APB register checks.
  Assumes the package and design files are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_ceu_top
  import ceu_pkg::*;
  ;
  // ----------------------------------------------------------------------
  // Signals and scoreboard state
  // ----------------------------------------------------------------------
  logic        pclk = 1'b0, presetn = 1'b0;  // Clock and active-low reset.
  logic [11:0] paddr = 12'h000;              // APB address.
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [2:0]  pprot = 3'h1;                 // Supervisor by default.
  logic        pready, pslverr, er, nmi = 1'b0, cmd_v = 1'b0, nm;
  ceu_req_t    cmd = '0, req, r;             // Command, presented, shadow.
  ceu_evt_t    evt, e;                       // Design event and expected.
  logic [2:0]  ctl = 3'h0;                   // Expected control bits.
  logic [5:0]  m_cause = 6'h00;              // Expected cause field.
  logic [31:0] m_ret = 32'h0, m_nra = 32'h0; // Expected return registers.
  logic        m_nested = 1'b0;              // Expected nested flag.
  int          errors = 0, n_checks = 0;
  // Causes in ranking order, highest first; force, step, trace follow.
  logic [5:0]  code [17] = '{6'h2d, 6'h2a, 6'h2b, 6'h2c, 6'h29, 6'h28, 6'h21, 6'h22,
                             6'h2e, 6'h27, 6'h24, 6'h23, 6'h26, 6'h27, 6'h24, 6'h23, 6'h26};

  always #12.5 pclk = ~pclk;

  ceu_pipe_model pipe (.pclk(pclk), .presetn(presetn), .cmd(cmd), .cmd_v(cmd_v), .req(req));
  ceu_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pprot(pprot), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req(req), .nmi_entry(nmi), .evt(evt));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("TB: checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; an edge first, so no signal is driven twice at once.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready.
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
    chk(er, xe);
  endtask

  // Expected event of the instruction in r, from the ranking table.
  task automatic predict();
    logic [19:0] f;
    int k;
    logic [5:0] c;
    logic [31:0] ra;
    f = {r.if_multi, r.if_misal & r.indirect, r.if_prot, r.if_miss, r.if_access,
         r.watch_match & ctl[2], r.undef, r.illegal_comb, r.sup_misuse, r.d0_multi, r.d0_misal,
         r.d0_prot | r.sup_data | r.dual_mmr, r.d0_miss, r.d1_multi, r.d1_misal, r.d1_prot,
         r.d1_miss, r.force_exc, ctl[0], r.trace_ovf & ctl[1]} & {20{r.valid}};
    k = -1;
    for (int i = 0; i < 20; i++)
      if (f[i]) k = 19 - i;
    e = '0;
    e.commit = r.valid;
    if (nm)
      m_nra = r.pc;
    if (k >= 0)
    begin
      er = (k < 17);
      c = (k == 17) ? {2'b00, r.force_code} : (k > 17 ? 6'h10 + 6'(k - 18) : code[k]);
      ra = !er ? r.next_pc : (k == 1 ? r.fetch_target : r.pc);
      // A nested exception is never taken and always blames the instruction.
      if (r.in_handler)
      begin
        c = 6'h25;
        ra = r.pc;
        er = 1'b1;
      end
      {m_cause, m_ret, m_nested} = {c, ra, r.in_handler};
      e.taken = !r.in_handler;
      e.unrecov = r.in_handler;
      e.commit = !er;
      e.abort_excepting = er;
      e.abort_younger = 1'b1;
    end
    e.cause = m_cause;
    e.ret_addr = m_ret;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h1f6021b3));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++)
      rchk(12'(i * 4), 32'h0, 1'b0);
    apb(1'b1, 12'h000, 32'h3f);
    chk(er, 1'b1);
    rchk(12'h000, 32'h0, 1'b0);
    rchk(12'h010, 32'h0, 1'b1);
    pprot <= 3'h0;
    rchk(12'h000, 32'h0, 1'b1);
    apb(1'b1, 12'h00c, 32'h7);
    chk(er, 1'b1);
    pprot <= 3'h1;
    rchk(12'h00c, 32'h0, 1'b0);
    $display("TB: register access test done");
    for (int it = 0; it < 400; it++)
    begin
      // Every so often change the enables and read the recorded state back.
      if (it % 25 == 0)
      begin
        ctl = 3'($urandom);
        apb(1'b1, 12'h00c, {29'h0, ctl});
        rchk(12'h00c, {29'h0, ctl}, 1'b0);
        rchk(12'h000, {25'h0, m_nested, m_cause}, 1'b0);
        rchk(12'h004, m_ret, 1'b0);
        rchk(12'h008, m_nra, 1'b0);
      end
      r = {$urandom % 8 != 0, $urandom, $urandom, $urandom, 1'($urandom), $urandom % 4 == 0,
           25'($urandom & $urandom & $urandom & $urandom)};
      r.force_code = 4'($urandom);
      nm = ($urandom % 6 == 0);
      @(posedge pclk);
      cmd <= r;
      cmd_v <= 1'b1;
      #1 chk(64'(evt.taken | evt.unrecov | evt.abort_younger), 64'h0);
      @(posedge pclk);
      cmd_v <= 1'b0;
      nmi <= nm;
      @(posedge pclk);
      nmi <= 1'b0;
      predict();
      #1 chk(64'(evt), 64'(e));
    end
    $display("TB: random instruction test done");
    report_and_stop();
  end

  // Whole run is about 1600 cycles; this limit is far beyond it.
  initial
  begin
    #500000;
    errors++;
    report_and_stop();
  end
endmodule // tb_ceu_top
`default_nettype wire
